// ==== pdmm_map.sv ====
// program and data memory address decoder with built-in general purpose ram
// Function
// RQ1: the program counter is 13 bits wide, spanning 8k words of 14 bits.
// RQ2: the small variant implements program words 0 to 3ff only.
// RQ3: the large variant implements program words 0 to 7ff only.
// RQ4: program addresses past the implemented size wrap by dropping upper bits.
// RQ5: after reset instruction fetch begins at word 0.
// RQ6: a taken interrupt sends fetch to word 4.
// RQ7: data memory has two banks, each holding special and general registers.
// RQ8: the lowest 32 locations of each bank decode as special function regs.
// RQ9: the small variant maps bank 0 locations 40h to 7fh to ram.
// RQ10: the large variant maps 20h to 7fh and a0h to bfh to ram.
// RQ11: bank 1 locations f0h to ffh reach the same storage as 70h to 7fh.
// RQ12: unimplemented data locations read as zero.
// RQ13: the bank select bit chooses bank 0 when low and bank 1 when high.
// RQ14: software keeps the indirect page and upper bank bits at zero.
// RQ15: direct addresses are the bank select bit above the 7-bit field.
`default_nettype none
module pdmm_map #(
    parameter bit LARGE = 1'b1
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic fetchAdvance,
    input wire logic intTake,
    input wire logic jumpValid,
    input wire logic [12:0] jumpAddr,
    input wire logic bankSelectBit,
    input wire pdmm_pkg::pdmm_dreq_t dataReq,
    input wire logic [7:0] sfrRdata,
    output logic [12:0] progCounter,
    output logic [12:0] progMemAddr,
    output logic [7:0] dataRdata,
    output logic dataRvalid,
    output logic sfrSel,
    output logic sfrWrite,
    output logic [4:0] sfrAddr,
    output logic [7:0] sfrWdata,
    output logic [7:0] dataAddr
);
    // pc state
    logic [12:0] pc_r, pc_nxt;
    logic [12:0] pma_r, pma_nxt;
    // data state
    logic [7:0] rdata_r, rdata_nxt;
    logic rvalid_r, rvalid_nxt;
    logic sfrSel_r, sfrSel_nxt;
    logic sfrWrite_r, sfrWrite_nxt;
    logic [4:0] sfrAddr_r, sfrAddr_nxt;
    logic [7:0] sfrWdata_r, sfrWdata_nxt;
    logic [7:0] daddr_r, daddr_nxt;
    logic pendSfr_r, pendSfr_nxt;
    logic [7:0] ram [0:127];
    logic [7:0] eff;
    logic [6:0] ramIdx;
    pdmm_pkg::pdmm_region_t region;

    // wrap into the implemented program space
    function automatic logic [12:0] wrapProg(input logic [12:0] a);
        return a & (LARGE ? pdmm_pkg::LARGE_PROG_MASK : pdmm_pkg::SMALL_PROG_MASK); // [RQ2] [RQ3] [RQ4]
    endfunction

    // classify an 8-bit data address as special register, ram or unimplemented
    function automatic pdmm_pkg::pdmm_region_t classify(input logic [7:0] a);
        logic b1;
        b1 = a[pdmm_pkg::BANK_BIT_POS];
        if (a[6:0] < pdmm_pkg::SFR_LIMIT) begin
            return pdmm_pkg::PDMM_SFR; // [RQ7] [RQ8]
        end
        if (!b1 && a >= (LARGE ? pdmm_pkg::LARGE_RAM_LO : pdmm_pkg::SMALL_RAM_LO)
                && a <= pdmm_pkg::BANK0_RAM_HI) begin
            return pdmm_pkg::PDMM_RAM; // [RQ9] [RQ10]
        end
        if (LARGE && a >= pdmm_pkg::BANK1_RAM_LO && a <= pdmm_pkg::BANK1_RAM_HI) begin
            return pdmm_pkg::PDMM_RAM; // [RQ10]
        end
        if (a >= pdmm_pkg::MIRROR_LO) begin
            return pdmm_pkg::PDMM_RAM; // [RQ11]
        end
        return pdmm_pkg::PDMM_NONE; // [RQ12]
    endfunction

    // program counter next value; interrupt outranks jump and advance
    always_comb begin
        pc_nxt = pc_r;
        if (intTake) begin
            pc_nxt = pdmm_pkg::INT_VECTOR; // [RQ6]
        end else if (jumpValid) begin
            pc_nxt = jumpAddr; // [RQ1]
        end else if (fetchAdvance) begin
            pc_nxt = 13'(pc_r + 13'h0001); // [RQ1]
        end
        if (reset) begin
            pc_nxt = pdmm_pkg::RESET_VECTOR; // [RQ5]
        end
        pma_nxt = wrapProg(pc_nxt); // [RQ4]
    end

    always_ff @(posedge clk) begin
        pc_r <= pc_nxt;
        pma_r <= pma_nxt;
    end

    // effective data address; indirect accesses carry a full address
    always_comb begin
        if (dataReq.indirect) begin
            eff = dataReq.addr;
        end else begin
            eff = {bankSelectBit, dataReq.field}; // [RQ13] [RQ15]
        end
        region = classify(eff);
        // mirror and bank 1 ram fold into one 128-byte array
        if (eff >= pdmm_pkg::MIRROR_LO) begin
            ramIdx = 7'(eff - pdmm_pkg::MIRROR_LO + pdmm_pkg::MIRROR_BASE); // [RQ11]
        end else if (eff[7]) begin
            ramIdx = 7'(eff - pdmm_pkg::BANK1_RAM_LO); // bank 1 ram uses free low slots
        end else begin
            ramIdx = eff[6:0];
        end
    end

    // data access next values; sfr reads return a cycle after select
    always_comb begin
        rdata_nxt = 8'h00;
        rvalid_nxt = 1'b0;
        sfrSel_nxt = 1'b0;
        sfrWrite_nxt = 1'b0;
        sfrAddr_nxt = sfrAddr_r;
        sfrWdata_nxt = sfrWdata_r;
        daddr_nxt = daddr_r;
        pendSfr_nxt = 1'b0;
        if (pendSfr_r) begin
            rdata_nxt = sfrRdata;
            rvalid_nxt = 1'b1;
        end
        if (dataReq.valid && !pendSfr_r) begin
            daddr_nxt = eff;
            case (region)
                pdmm_pkg::PDMM_SFR: begin
                    sfrSel_nxt = 1'b1; // [RQ8]
                    sfrWrite_nxt = dataReq.write;
                    sfrAddr_nxt = eff[4:0];
                    sfrWdata_nxt = dataReq.wdata;
                    pendSfr_nxt = !dataReq.write;
                end
                pdmm_pkg::PDMM_RAM: begin
                    rdata_nxt = ram[ramIdx];
                    rvalid_nxt = !dataReq.write;
                end
                pdmm_pkg::PDMM_NONE: begin
                    rdata_nxt = 8'h00; // [RQ12]
                    rvalid_nxt = !dataReq.write;
                end
                default: begin
                    rdata_nxt = 8'h00;
                end
            endcase
        end
        if (reset) begin
            rvalid_nxt = 1'b0;
            sfrSel_nxt = 1'b0;
            sfrWrite_nxt = 1'b0;
            pendSfr_nxt = 1'b0;
            rdata_nxt = 8'h00;
            sfrAddr_nxt = 5'h00;
            sfrWdata_nxt = 8'h00;
            daddr_nxt = 8'h00;
        end
    end

    always_ff @(posedge clk) begin
        rdata_r <= rdata_nxt;
        rvalid_r <= rvalid_nxt;
        sfrSel_r <= sfrSel_nxt;
        sfrWrite_r <= sfrWrite_nxt;
        sfrAddr_r <= sfrAddr_nxt;
        sfrWdata_r <= sfrWdata_nxt;
        daddr_r <= daddr_nxt;
        pendSfr_r <= pendSfr_nxt;
    end

    // ram storage keeps contents across reset, as static ram does
    always_ff @(posedge clk) begin
        if (!reset && dataReq.valid && !pendSfr_r && dataReq.write
                && region == pdmm_pkg::PDMM_RAM) begin
            ram[ramIdx] <= dataReq.wdata; // [RQ9] [RQ10] [RQ11]
        end
    end

    assign progCounter = pc_r;
    assign progMemAddr = pma_r;
    assign dataRdata = rdata_r;
    assign dataRvalid = rvalid_r;
    assign sfrSel = sfrSel_r;
    assign sfrWrite = sfrWrite_r;
    assign sfrAddr = sfrAddr_r;
    assign sfrWdata = sfrWdata_r;
    assign dataAddr = daddr_r;

    // checks
    chk_reset_vector: assert property (@(posedge clk) reset |=> pc_r == 13'h0000) // [RQ5]
        else $error("fetch did not restart at zero");
    chk_int_vector: assert property (@(posedge clk) disable iff (reset)
        intTake |=> pc_r == 13'h0004) // [RQ6]
        else $error("interrupt did not reach vector four");
    chk_prog_wrap: assert property (@(posedge clk) disable iff (reset)
        pma_r == (pc_r & (LARGE ? 13'h07ff : 13'h03ff))) // [RQ4]
        else $error("program address not wrapped");
    chk_advance_step: assert property (@(posedge clk) disable iff (reset)
        fetchAdvance && !intTake && !jumpValid |=> pc_r == 13'($past(pc_r) + 13'h0001)) // [RQ1]
        else $error("pc did not step by one");
    chk_sfr_decode: assert property (@(posedge clk) disable iff (reset)
        sfrSel_r |-> dataAddr[6:0] < 7'h20) // [RQ8]
        else $error("special select outside low block");
    chk_direct_bank: assert property (@(posedge clk) disable iff (reset)
        dataReq.valid && !dataReq.indirect && !pendSfr_r
        |=> dataAddr == {$past(bankSelectBit), $past(dataReq.field)}) // [RQ13] [RQ15]
        else $error("direct address not formed from bank bit");
    chk_unimpl_zero: assert property (@(posedge clk) disable iff (reset)
        dataReq.valid && !dataReq.write && !pendSfr_r && region == pdmm_pkg::PDMM_NONE
        |=> dataRvalid && dataRdata == 8'h00) // [RQ12]
        else $error("unimplemented read not zero");
    chk_mirror_alias: assert property (@(posedge clk) disable iff (reset)
        dataReq.valid && dataReq.write && !pendSfr_r && dataReq.indirect
        && dataReq.addr >= 8'hf0 ##2 dataReq.valid && !dataReq.write && dataReq.indirect
        && !pendSfr_r && dataReq.addr == 8'($past(dataReq.addr, 2) - 8'h80)
        |=> dataRdata == $past(dataReq.wdata, 3)) // [RQ11]
        else $error("mirror did not alias bank 0");
    chk_sfr_read_lat: assert property (@(posedge clk) disable iff (reset)
        sfrSel_r && !sfrWrite_r |=> dataRvalid) // [RQ7]
        else $error("special read answer missing");
    cov_interrupt: cover property (@(posedge clk) disable iff (reset) intTake ##1 fetchAdvance);
    cov_mirror_rd: cover property (@(posedge clk) disable iff (reset)
        dataReq.valid && eff >= 8'hf0);
    cov_sfr_read: cover property (@(posedge clk) disable iff (reset) sfrSel_r && !sfrWrite_r);
    cov_wrap: cover property (@(posedge clk) disable iff (reset) pc_r != pma_r);

    // bank 1 ram below the mirror, large variant only
    cov_bank1_ram: cover property (@(posedge clk) disable iff (reset)
        dataReq.valid && region == pdmm_pkg::PDMM_RAM && eff[7] && eff < 8'hf0);

    // fetch address also restarts, not only the counter
    chk_reset_fetch_addr: assert property (@(posedge clk) // [RQ5]
        reset |=> pma_r == pdmm_pkg::RESET_VECTOR)
        else $error("fetch address did not restart at zero");

    // no stale strobe may survive a reset
    chk_reset_data_idle: assert property (@(posedge clk) // [RQ5]
        reset |=> !rvalid_r && !sfrSel_r && !pendSfr_r)
        else $error("data strobes not idle after reset");

    // jump loads the full 13-bit address
    chk_jump_load: assert property (@(posedge clk) disable iff (reset) // [RQ1]
        jumpValid && !intTake |=> pc_r == $past(jumpAddr))
        else $error("jump target not loaded");

    // vector fetch address is already inside both memory sizes
    chk_int_fetch_addr: assert property (@(posedge clk) disable iff (reset) // [RQ6]
        intTake |=> pma_r == pdmm_pkg::INT_VECTOR)
        else $error("interrupt fetch address wrong");

    // without a request the counter must hold
    chk_pc_hold: assert property (@(posedge clk) disable iff (reset) // [RQ1]
        !fetchAdvance && !intTake && !jumpValid |=> pc_r == $past(pc_r))
        else $error("pc moved without a request");

    // fetch address never leaves the implemented words
    chk_prog_in_range: assert property (@(posedge clk) disable iff (reset) // [RQ2] [RQ3]
        pma_r <= (LARGE ? pdmm_pkg::LARGE_PROG_MASK : pdmm_pkg::SMALL_PROG_MASK))
        else $error("fetch address beyond implemented memory");

    // a taken special access strobes with the low five bits
    chk_sfr_addr_low: assert property (@(posedge clk) disable iff (reset) // [RQ8]
        dataReq.valid && !pendSfr_r && region == pdmm_pkg::PDMM_SFR
        |=> sfrSel_r && sfrAddr_r == $past(eff[4:0]))
        else $error("special access not strobed");

    // ram and empty space never disturb the special registers
    chk_ram_no_strobe: assert property (@(posedge clk) disable iff (reset) // [RQ9] [RQ10]
        dataReq.valid && !pendSfr_r && region != pdmm_pkg::PDMM_SFR |=> !sfrSel_r)
        else $error("special strobe on a ram access");

    // requests while a special read is pending are dropped
    chk_pending_drop: assert property (@(posedge clk) disable iff (reset) // [RQ8]
        pendSfr_r |=> !sfrSel_r)
        else $error("request taken during pending read");

    // writes give no read answer, which the core would mistake for data
    chk_write_no_answer: assert property (@(posedge clk) disable iff (reset) // [RQ9]
        dataReq.valid && dataReq.write && !pendSfr_r |=> !rvalid_r)
        else $error("write produced a read answer");

    // small variant has no bank 1 ram outside the mirror
    chk_small_no_bank1: assert property (@(posedge clk) disable iff (reset) // [RQ9] [RQ12]
        !LARGE && eff[7] && eff < pdmm_pkg::MIRROR_LO && eff[6:0] >= pdmm_pkg::SFR_LIMIT
        |-> region == pdmm_pkg::PDMM_NONE)
        else $error("small variant decoded bank 1 ram");

    // large variant decodes the whole bank 1 ram window
    chk_large_bank1_ram: assert property (@(posedge clk) disable iff (reset) // [RQ10]
        LARGE && eff >= pdmm_pkg::BANK1_RAM_LO && eff <= pdmm_pkg::BANK1_RAM_HI
        |-> region == pdmm_pkg::PDMM_RAM)
        else $error("bank 1 ram not decoded");

    // mirror shares the slots of the top of bank 0
    chk_mirror_slot: assert property (@(posedge clk) disable iff (reset) // [RQ11]
        eff >= pdmm_pkg::MIRROR_LO |-> ramIdx == 7'(eff - 8'h80))
        else $error("mirror slot differs from bank 0");

    // bank 0 ram sits at its own low seven bits
    chk_bank0_slot: assert property (@(posedge clk) disable iff (reset) // [RQ9] [RQ10]
        !eff[7] && region == pdmm_pkg::PDMM_RAM |-> ramIdx == eff[6:0])
        else $error("bank 0 ram slot wrong");
endmodule : pdmm_map
`default_nettype wire

// ==== pdmm_pkg.sv ====
// package for the program and data memory map decoder
`default_nettype none
package pdmm_pkg;
    localparam int PC_WIDTH = 13;
    localparam int INSN_WIDTH = 14;
    localparam int DATA_WIDTH = 8;
    localparam int DADDR_WIDTH = 8;
    localparam logic [12:0] RESET_VECTOR = 13'h0000;
    localparam logic [12:0] INT_VECTOR = 13'h0004;
    localparam logic [12:0] SMALL_PROG_MASK = 13'h03ff;
    localparam logic [12:0] LARGE_PROG_MASK = 13'h07ff;
    localparam logic [6:0] SFR_LIMIT = 7'h20;
    localparam logic [7:0] SMALL_RAM_LO = 8'h40;
    localparam logic [7:0] LARGE_RAM_LO = 8'h20;
    localparam logic [7:0] BANK0_RAM_HI = 8'h7f;
    localparam logic [7:0] BANK1_RAM_LO = 8'ha0;
    localparam logic [7:0] BANK1_RAM_HI = 8'hbf;
    localparam logic [7:0] MIRROR_LO = 8'hf0;
    localparam logic [7:0] MIRROR_BASE = 8'h70;
    localparam int BANK_BIT_POS = 7;

    // data access request from the core
    typedef struct packed {
        logic valid;
        logic write;
        logic indirect;
        logic [7:0] addr;
        logic [6:0] field;
        logic [7:0] wdata;
    } pdmm_dreq_t;

    // decoded data access towards storage
    typedef enum logic [1:0] {PDMM_NONE, PDMM_SFR, PDMM_RAM} pdmm_region_t;
endpackage : pdmm_pkg
`default_nettype wire

// ==== pdmm_sfr_model.sv ====
// behavioural special register file answering the decoder's select strobe
`default_nettype none
module pdmm_sfr_model (
    input wire logic clk,
    input wire logic sfrSel,
    input wire logic sfrWrite,
    input wire logic [4:0] sfrAddr,
    output logic [7:0] sfrRdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] last_r;
    // answer only while selected for a read, otherwise show a changing value
    always_comb begin
        sfrRdata = (sfrSel && !sfrWrite) ? {3'h5, sfrAddr} : ~last_r;
    end
    // remember the last value so an idle bus never repeats it
    always_ff @(posedge clk) begin
        last_r <= sfrRdata;
    end
endmodule // pdmm_sfr_model
`default_nettype wire

// ==== tb_program_and_data_memory_map.sv ====
// self-checking bench for the program and data memory map decoder
`default_nettype none
module tb_program_and_data_memory_map;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic fetchAdvance = 1'b0;
    logic intTake = 1'b0;
    logic jumpValid = 1'b0;
    logic [12:0] jumpAddr = 13'h0000;
    logic bankSelectBit = 1'b0;
    pdmm_pkg::pdmm_dreq_t dataReq = '0;
    logic [7:0] sfrRdata, dataRdata, sfrWdata, dataAddr, rd;
    logic [12:0] progCounter, progMemAddr;
    logic dataRvalid, sfrSel, sfrWrite;
    logic [4:0] sfrAddr;
    logic [12:0] pmaSmall;
    logic [7:0] rdSmall;
    int errors = 0;
    int totalChecks = 0;

    pdmm_map DUT (.clk(clk), .reset(reset), .fetchAdvance(fetchAdvance), .intTake(intTake),
        .jumpValid(jumpValid), .jumpAddr(jumpAddr), .bankSelectBit(bankSelectBit),
        .dataReq(dataReq), .sfrRdata(sfrRdata), .progCounter(progCounter),
        .progMemAddr(progMemAddr), .dataRdata(dataRdata), .dataRvalid(dataRvalid),
        .sfrSel(sfrSel), .sfrWrite(sfrWrite), .sfrAddr(sfrAddr), .sfrWdata(sfrWdata),
        .dataAddr(dataAddr));
    pdmm_sfr_model sfrModel (.clk(clk), .sfrSel(sfrSel), .sfrWrite(sfrWrite),
        .sfrAddr(sfrAddr), .sfrRdata(sfrRdata));
    // small variant sees the same stimulus
    pdmm_map #(.LARGE(1'b0)) dutSmall (.clk(clk), .reset(reset), .fetchAdvance(fetchAdvance),
        .intTake(intTake), .jumpValid(jumpValid), .jumpAddr(jumpAddr),
        .bankSelectBit(bankSelectBit), .dataReq(dataReq), .sfrRdata(sfrRdata),
        .progCounter(), .progMemAddr(pmaSmall), .dataRdata(rdSmall), .dataRvalid(),
        .sfrSel(), .sfrWrite(), .sfrAddr(), .sfrWdata(), .dataAddr());

    // free-running core clock, 100 ns period
    initial begin
        forever #50 clk = ~clk;
    end

    task automatic finish_test();
        $display("checks %0d errors %0d", totalChecks, errors);
        if (errors == 0 && totalChecks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input logic [12:0] got, input logic [12:0] exp);
        totalChecks++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one program cycle, then settle past the edge that takes it
    task automatic pc_step(input logic adv, input logic intr, input logic jmp,
        input logic [12:0] addr);
        @(posedge clk);
        fetchAdvance <= adv;
        intTake <= intr;
        jumpValid <= jmp;
        jumpAddr <= addr;
        @(posedge clk);
        fetchAdvance <= 1'b0;
        intTake <= 1'b0;
        jumpValid <= 1'b0;
        #1;
    endtask

    // one data access; reads wait a bounded time because sfr reads take two cycles
    task automatic data_op(input logic wr, input logic ind, input logic bank,
        input logic [7:0] addr, input logic [7:0] wd);
        int n;
        @(posedge clk);
        bankSelectBit <= bank; // reserved page bits stay zero here
        dataReq <= '{valid: 1'b1, write: wr, indirect: ind, addr: addr, field: addr[6:0],
            wdata: wd};
        @(posedge clk);
        dataReq.valid <= 1'b0;
        #1;
        for (n = 0; !wr && dataRvalid !== 1'b1 && n < 4; n++) begin
            @(posedge clk);
            #1;
        end
        if (n == 4) begin
            errors++;
            finish_test();
        end
        rd = dataRdata;
    endtask

    task automatic test_program();
        check(progCounter, 13'h0000);
        pc_step(1'b1, 1'b0, 1'b1, 13'h1ffe);
        check(progMemAddr, 13'h07fe);
        check(pmaSmall, 13'h03fe);
        pc_step(1'b1, 1'b0, 1'b0, 13'h0000);
        check(progMemAddr, 13'h07ff);
        check(pmaSmall, 13'h03ff);
        pc_step(1'b1, 1'b0, 1'b0, 13'h0000);
        check(progCounter, 13'h0000);
        pc_step(1'b1, 1'b1, 1'b1, 13'h0100);
        check(progCounter, 13'h0004);
        check(progMemAddr, 13'h0004);
        // mid-run reset must return fetch to word zero
        @(posedge clk);
        reset <= 1'b1;
        @(posedge clk);
        reset <= 1'b0;
        #1;
        check(progCounter, 13'h0000);
    endtask

    task automatic test_ram();
        data_op(1'b1, 1'b1, 1'b0, 8'h20, 8'h11);
        data_op(1'b1, 1'b0, 1'b1, 8'h20, 8'h22);
        data_op(1'b1, 1'b1, 1'b0, 8'hf5, 8'h5a);
        data_op(1'b0, 1'b1, 1'b0, 8'h75, 8'h00);
        check({5'h00, rd}, 13'h005a);
        data_op(1'b1, 1'b1, 1'b0, 8'h7f, 8'h33);
        data_op(1'b0, 1'b1, 1'b0, 8'h20, 8'h00);
        check({5'h00, rd}, 13'h0011);
        check({5'h00, rdSmall}, 13'h0000);
        data_op(1'b0, 1'b1, 1'b1, 8'ha0, 8'h00);
        check({5'h00, rd}, 13'h0022);
        data_op(1'b0, 1'b0, 1'b1, 8'h7f, 8'h00);
        check({5'h00, rd}, 13'h0033);
        check({5'h00, rdSmall}, 13'h0033);
        data_op(1'b0, 1'b1, 1'b0, 8'hc0, 8'h00);
        check({5'h00, rd}, 13'h0000);
    endtask

    task automatic test_sfr();
        data_op(1'b0, 1'b0, 1'b1, 8'h03, 8'h00);
        check({5'h00, dataAddr}, 13'h0083);
        check({5'h00, rd}, 13'h00a3);
        data_op(1'b0, 1'b1, 1'b0, 8'h9f, 8'h00);
        check({5'h00, rd}, 13'h00bf);
        data_op(1'b1, 1'b0, 1'b0, 8'h05, 8'h77);
        check({3'h0, sfrSel, sfrWrite, sfrWdata}, 13'h0377);
        check({8'h00, sfrAddr}, 13'h0005);
    endtask

    // reset for 16 cycles, then the scenarios in turn
    initial begin
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        test_program();
        test_ram();
        test_sfr();
        finish_test();
    end
endmodule // tb_program_and_data_memory_map
`default_nettype wire
